/* src/afswf_fir.sv */
// One programmable 8/9-tap edge filter: tap expansion and convolution.
// Assumes a nine-pixel window, oldest pixel in the low byte.
`timescale 1ns/1ps
`default_nettype none
`include "afswf_regs.svh"

module afswf_fir (
   // Clock and reset, used by the checks only
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Pixel window
   input wire logic [71:0] taps_i,
   // Filter configuration
   input wire afswf_pkg::afswf_reg_t cfg_a_i,
   input wire afswf_pkg::afswf_reg_t cfg_b_i,
   // Filter result
   output logic [16:0] mag_o,
   output logic [3:0] shift_o
);
   import afswf_pkg::*;

   afswf_coef_t coef_w [5];
   afswf_coef_t tap_w [9];
   logic nine_w;
   afswf_sym_t mode_w;
   logic signed [17:0] sum_w;

   // Out-of-range code -16 is pulled to -15
   function automatic afswf_coef_t clamp(input logic [4:0] raw);
      clamp = (raw == `AFSWF_COEF_BAD) ? `AFSWF_COEF_MIN : raw;
   endfunction

   // ----------------------------------------------------------------------
   // Tap expansion
   // ----------------------------------------------------------------------
   always_comb begin
      nine_w = cfg_a_i[`AFSWF_SIZE_BIT];
      mode_w = cfg_a_i[`AFSWF_ANTI_BIT] ? AFSWF_ANTI : AFSWF_SYM;
      coef_w[0] = clamp(cfg_a_i[`AFSWF_C0_LSB +: 5]);
      coef_w[1] = clamp(cfg_b_i[`AFSWF_C1_LSB +: 5]);
      coef_w[2] = clamp(cfg_b_i[`AFSWF_C2_LSB +: 5]);
      coef_w[3] = clamp(cfg_b_i[`AFSWF_C3_LSB +: 5]);
      coef_w[4] = clamp(cfg_a_i[`AFSWF_C4_LSB +: 5]);
      for (int i = 0; i < 9; i++) begin
         tap_w[i] = 5'sh00;
      end
      if (nine_w && mode_w == AFSWF_SYM) begin
         tap_w[4] = coef_w[0];
      end
      for (int i = 1; i <= 4; i++) begin
         tap_w[4 - i] = (mode_w == AFSWF_ANTI) ? -coef_w[i] : coef_w[i];
         tap_w[nine_w ? 4 + i : 3 + i] = coef_w[i];
      end
   end

   // ----------------------------------------------------------------------
   // Convolution and weight
   // ----------------------------------------------------------------------
   always_comb begin
      sum_w = 18'sh00000;
      for (int i = 0; i < 9; i++) begin
         sum_w = sum_w + $signed({10'h000, taps_i[i*8 +: 8]}) * tap_w[i];
      end
      mag_o = sum_w[17] ? 17'(-sum_w) : sum_w[16:0];
      if (cfg_a_i[`AFSWF_WGT_LSB +: 4] > `AFSWF_WGT_MAX) begin
         shift_o = `AFSWF_WGT_MAX;
      end else begin
         shift_o = cfg_a_i[`AFSWF_WGT_LSB +: 4];
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_sym_mirror: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (mode_w == AFSWF_SYM) |-> (nine_w ?
         (tap_w[0] == tap_w[8] && tap_w[1] == tap_w[7] &&
          tap_w[2] == tap_w[6] && tap_w[3] == tap_w[5]) :
         (tap_w[0] == tap_w[7] && tap_w[1] == tap_w[6] &&
          tap_w[2] == tap_w[5] && tap_w[3] == tap_w[4])))
      else $error("symmetric taps do not mirror");
   a_anti_mirror: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (mode_w == AFSWF_ANTI) |-> (nine_w ?
         (tap_w[0] == -tap_w[8] && tap_w[3] == -tap_w[5] &&
          tap_w[4] == 5'sh00) :
         (tap_w[0] == -tap_w[7] && tap_w[3] == -tap_w[4])))
      else $error("antisymmetric taps do not negate");
   a_centre_tap: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (nine_w && mode_w == AFSWF_SYM) |-> tap_w[4] == coef_w[0])
      else $error("centre coefficient not at middle tap");
   a_spare_tap: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !nine_w |-> (tap_w[8] == 5'sh00 && tap_w[7] == coef_w[4]))
      else $error("eight-tap filter uses ninth tap");
   a_coef_range: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      shift_o <= `AFSWF_WGT_MAX && tap_w[0] != 5'sh10 && tap_w[4] != 5'sh10)
      else $error("coefficient or weight out of range");
endmodule
`default_nettype wire

/* src/afswf_pkg.sv */
// Types shared by the auto-focus sharpness window filter modules.
// Assumes the constants of afswf_regs.svh are included where needed.
package afswf_pkg;
   typedef logic [7:0] afswf_pix_t;
   typedef logic [15:0] afswf_reg_t;
   typedef logic signed [4:0] afswf_coef_t;
   typedef struct packed {
      logic hit;
      logic [1:0] idx;
   } afswf_loc_t;
   typedef enum logic [1:0] {
      AFSWF_SYM = 2'b01,
      AFSWF_ANTI = 2'b10
   } afswf_sym_t;
endpackage

/* src/afswf_regs.svh */
// Register offsets, field positions, reset values and fixed counts of the
// auto-focus sharpness window filter.
// Assumes 8-bit register indices and 16-bit register data.
`ifndef AFSWF_REGS_SVH
`define AFSWF_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define AFSWF_ORG_Y_OFS 8'h3F
`define AFSWF_WIN_W_OFS 8'h40
`define AFSWF_WIN_H_OFS 8'h41
`define AFSWF_ORG_X_OFS 8'h42
`define AFSWF_LUMA_OFS 8'h43
`define AFSWF_F1A_OFS 8'h4B
`define AFSWF_F1B_OFS 8'h4C
`define AFSWF_S1_OFS 8'h4D
`define AFSWF_F2A_OFS 8'h55
`define AFSWF_F2B_OFS 8'h56
`define AFSWF_S2_OFS 8'h57
`define AFSWF_RES_REGS 8'h08

// ----------------------------------------------------------------------
// Filter configuration fields
// ----------------------------------------------------------------------
`define AFSWF_SIZE_BIT 0
`define AFSWF_ANTI_BIT 1
`define AFSWF_WGT_LSB 2
`define AFSWF_C0_LSB 6
`define AFSWF_C4_LSB 11
`define AFSWF_C1_LSB 0
`define AFSWF_C2_LSB 5
`define AFSWF_C3_LSB 10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define AFSWF_ORG_Y_RST 16'h0000
`define AFSWF_WIN_W_RST 16'h0040
`define AFSWF_WIN_H_RST 16'h0040
`define AFSWF_ORG_X_RST 16'h0008
`define AFSWF_F1A_RST 16'h09A9
`define AFSWF_F1B_RST 16'h0380
`define AFSWF_F2A_RST 16'h0024
`define AFSWF_F2B_RST 16'h0B26

// ----------------------------------------------------------------------
// Fixed counts
// ----------------------------------------------------------------------
`define AFSWF_HALF_TAPS 4
`define AFSWF_WGT_UNITY 9
`define AFSWF_WGT_MAX 4'hE
`define AFSWF_COEF_BAD 5'h10
`define AFSWF_COEF_MIN 5'h11

`endif

/* src/afswf_top.sv */
// Auto-focus sharpness window filter: 4x4 window grid, two edge filters,
// sharpness scores and average luminance per window, register file.
// Assumes luminance arrives row by row, one pixel per valid cycle, with a
// frame start pulse before the first row and a line end pulse after each
// row in a cycle of its own.
//
// Summary of operation
// - Each window yields two scores, one average
// - Rows processed per window are counted
// - Results written only when rows equal height
// - Short windows keep their old results
// - Results written right after window's last row
// - Symmetric filters mirror four or five coefficients
// - Antisymmetric filters negate mirrors, zero centre
// - Centre coefficient middle tap; weight scales taps
// - Sixteen windows on programmable grid
// - Coefficients -15..15, weight 1/512 to 32
// - Absolute outputs, pixels and luminance accumulated
// - Results are eight-bit fields, wrapping
`timescale 1ns/1ps
`default_nettype none
`include "afswf_regs.svh"

module afswf_top #(
   parameter int XY_W = 16,
   parameter int CNT_W = 22,
   parameter int ACC_W = 56
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Luminance stream
   input wire logic frame_start_i,
   input wire logic line_end_i,
   input wire logic pix_valid_i,
   input wire afswf_pkg::afswf_pix_t pix_y_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire afswf_pkg::afswf_reg_t reg_wdata_i,
   input wire logic reg_rd_i,
   output afswf_pkg::afswf_reg_t reg_rdata_o,
   output logic reg_rdata_valid_o
);
   import afswf_pkg::*;

   localparam int LSUM_W = CNT_W + 8;

   afswf_reg_t org_y_ff, win_w_ff, win_h_ff, org_x_ff;
   afswf_reg_t f1a_ff, f1b_ff, f2a_ff, f2b_ff;
   logic [127:0] luma_res_ff, s1_res_ff, s2_res_ff;
   logic [71:0] taps_ff;
   logic [XY_W-1:0] x_ff, y_ff, cen_x_ff, cen_y_ff, line_y_ff;
   logic cen_ff, line_end_ff;
   logic [ACC_W-1:0] acc1_ff [4];
   logic [ACC_W-1:0] acc2_ff [4];
   logic [LSUM_W-1:0] lsum_ff [4];
   logic [CNT_W-1:0] pcnt_ff [4];
   logic [15:0] rows_ff [4];
   logic [16:0] mag1_w, mag2_w;
   logic [3:0] sh1_w, sh2_w;
   logic [ACC_W-1:0] sc1_w, sc2_w;
   afswf_loc_t cx_loc, cy_loc, ly_loc;
   logic cen_hit_w, row_hit_w;
   logic [7:0] avg_w [4];
   afswf_reg_t nxt_rdata;

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   function automatic afswf_loc_t locate(input logic [XY_W-1:0] p,
                                         input logic [XY_W-1:0] org,
                                         input logic [XY_W-1:0] sz);
      logic [XY_W+1:0] d;
      afswf_loc_t r;
      d = {2'b00, p} - {2'b00, org};
      r.hit = 1'b0;
      r.idx = 2'd0;
      if (p >= org) begin
         if (d < {2'b00, sz}) begin
            r.hit = 1'b1;
         end else if (d < {1'b0, sz, 1'b0}) begin
            r.hit = 1'b1;
            r.idx = 2'd1;
         end else if (d < {2'b00, sz} + {1'b0, sz, 1'b0}) begin
            r.hit = 1'b1;
            r.idx = 2'd2;
         end else if (d < {sz, 2'b00}) begin
            r.hit = 1'b1;
            r.idx = 2'd3;
         end
      end
      locate = r;
   endfunction

   function automatic logic [ACC_W-1:0] scale(input logic [16:0] mag,
                                              input logic [3:0] sh);
      scale = ACC_W'(mag) << sh;
   endfunction

   function automatic logic [7:0] avg(input logic [LSUM_W-1:0] s,
                                      input logic [CNT_W-1:0] n);
      logic [7:0] q;
      logic [7:0] trial;
      logic [CNT_W+15:0] prod;
      q = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         trial = q | 8'(1 << b);
         prod = {{(CNT_W+8){1'b0}}, trial} * {16'h0000, n};
         if (prod <= {8'h00, s}) begin
            q = trial;
         end
      end
      avg = q;
   endfunction

   function automatic afswf_reg_t res_word(input logic [127:0] v,
                                           input logic [7:0] a,
                                           input logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      res_word = (d < `AFSWF_RES_REGS) ? v[d[2:0]*16 +: 16] : 16'h0000;
   endfunction

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         org_y_ff <= `AFSWF_ORG_Y_RST;
         win_w_ff <= `AFSWF_WIN_W_RST;
         win_h_ff <= `AFSWF_WIN_H_RST;
         org_x_ff <= `AFSWF_ORG_X_RST;
         f1a_ff <= `AFSWF_F1A_RST;
         f1b_ff <= `AFSWF_F1B_RST;
         f2a_ff <= `AFSWF_F2A_RST;
         f2b_ff <= `AFSWF_F2B_RST;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `AFSWF_ORG_Y_OFS: org_y_ff <= reg_wdata_i;
            `AFSWF_WIN_W_OFS: win_w_ff <= reg_wdata_i;
            `AFSWF_WIN_H_OFS: win_h_ff <= reg_wdata_i;
            `AFSWF_ORG_X_OFS: org_x_ff <= reg_wdata_i;
            `AFSWF_F1A_OFS: f1a_ff <= reg_wdata_i;
            `AFSWF_F1B_OFS: f1b_ff <= reg_wdata_i;
            `AFSWF_F2A_OFS: f2a_ff <= reg_wdata_i;
            `AFSWF_F2B_OFS: f2b_ff <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   always_comb begin
      nxt_rdata = res_word(luma_res_ff, reg_addr_i, `AFSWF_LUMA_OFS) |
                  res_word(s1_res_ff, reg_addr_i, `AFSWF_S1_OFS) |
                  res_word(s2_res_ff, reg_addr_i, `AFSWF_S2_OFS);
      case (reg_addr_i)
         `AFSWF_ORG_Y_OFS: nxt_rdata = org_y_ff;
         `AFSWF_WIN_W_OFS: nxt_rdata = win_w_ff;
         `AFSWF_WIN_H_OFS: nxt_rdata = win_h_ff;
         `AFSWF_ORG_X_OFS: nxt_rdata = org_x_ff;
         `AFSWF_F1A_OFS: nxt_rdata = f1a_ff;
         `AFSWF_F1B_OFS: nxt_rdata = f1b_ff;
         `AFSWF_F2A_OFS: nxt_rdata = f2a_ff;
         `AFSWF_F2B_OFS: nxt_rdata = f2b_ff;
         default: ;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 16'h0000;
         reg_rdata_valid_o <= 1'b0;
      end else begin
         reg_rdata_valid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= nxt_rdata;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Pixel position and filter window
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || frame_start_i) begin
         x_ff <= '0;
         y_ff <= '0;
      end else if (line_end_i) begin
         x_ff <= '0;
         y_ff <= y_ff + XY_W'(1);
      end else if (pix_valid_i) begin
         x_ff <= x_ff + XY_W'(1);
      end
   end

   // A centre needs four pixels of the same row on each side
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         taps_ff <= '0;
         cen_ff <= 1'b0;
         cen_x_ff <= '0;
         cen_y_ff <= '0;
         line_end_ff <= 1'b0;
         line_y_ff <= '0;
      end else begin
         if (pix_valid_i) begin
            taps_ff <= {pix_y_i, taps_ff[71:8]};
         end
         cen_ff <= pix_valid_i && x_ff >= XY_W'(2 * `AFSWF_HALF_TAPS);
         cen_x_ff <= x_ff - XY_W'(`AFSWF_HALF_TAPS);
         cen_y_ff <= y_ff;
         line_end_ff <= line_end_i && !frame_start_i;
         line_y_ff <= y_ff;
      end
   end

   afswf_fir u_fir1 (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .taps_i(taps_ff),
      .cfg_a_i(f1a_ff),
      .cfg_b_i(f1b_ff),
      .mag_o(mag1_w),
      .shift_o(sh1_w)
   );

   afswf_fir u_fir2 (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .taps_i(taps_ff),
      .cfg_a_i(f2a_ff),
      .cfg_b_i(f2b_ff),
      .mag_o(mag2_w),
      .shift_o(sh2_w)
   );

   // ----------------------------------------------------------------------
   // Window grid
   // ----------------------------------------------------------------------
   always_comb begin
      sc1_w = scale(mag1_w, sh1_w);
      sc2_w = scale(mag2_w, sh2_w);
      cx_loc = locate(cen_x_ff, org_x_ff, win_w_ff);
      cy_loc = locate(cen_y_ff, org_y_ff, win_h_ff);
      ly_loc = locate(line_y_ff, org_y_ff, win_h_ff);
      cen_hit_w = cen_ff && cx_loc.hit && cy_loc.hit;
      row_hit_w = line_end_ff && ly_loc.hit &&
                  (rows_ff[ly_loc.idx] + 16'h0001 == win_h_ff);
      for (int c = 0; c < 4; c++) begin
         avg_w[c] = avg(lsum_ff[c], pcnt_ff[c]);
      end
   end

   // ----------------------------------------------------------------------
   // Accumulation for the four windows of the current grid row
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || frame_start_i || row_hit_w) begin
         for (int c = 0; c < 4; c++) begin
            acc1_ff[c] <= '0;
            acc2_ff[c] <= '0;
            lsum_ff[c] <= '0;
            pcnt_ff[c] <= '0;
         end
      end else if (cen_hit_w) begin
         acc1_ff[cx_loc.idx] <= acc1_ff[cx_loc.idx] + sc1_w;
         acc2_ff[cx_loc.idx] <= acc2_ff[cx_loc.idx] + sc2_w;
         lsum_ff[cx_loc.idx] <= lsum_ff[cx_loc.idx] +
                                LSUM_W'(taps_ff[39:32]);
         pcnt_ff[cx_loc.idx] <= pcnt_ff[cx_loc.idx] + CNT_W'(1);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || frame_start_i) begin
         for (int r = 0; r < 4; r++) begin
            rows_ff[r] <= 16'h0000;
         end
      end else if (line_end_ff && ly_loc.hit) begin
         rows_ff[ly_loc.idx] <= rows_ff[ly_loc.idx] + 16'h0001;
      end
   end

   // ----------------------------------------------------------------------
   // Result registers, two windows per word
   // ----------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         luma_res_ff <= '0;
         s1_res_ff <= '0;
         s2_res_ff <= '0;
      end else if (row_hit_w && !frame_start_i) begin
         for (int c = 0; c < 4; c++) begin
            if (pcnt_ff[c] != '0) begin
               luma_res_ff[({ly_loc.idx, 2'(c)})*8 +: 8] <= avg_w[c];
               s1_res_ff[({ly_loc.idx, 2'(c)})*8 +: 8] <=
                  acc1_ff[c][`AFSWF_WGT_UNITY +: 8];
               s2_res_ff[({ly_loc.idx, 2'(c)})*8 +: 8] <=
                  acc2_ff[c][`AFSWF_WGT_UNITY +: 8];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_results_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !row_hit_w |=> ($stable(luma_res_ff) && $stable(s1_res_ff) &&
                      $stable(s2_res_ff)))
      else $error("results changed without a complete window");
   a_commit_height: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      ($changed(s1_res_ff) || $changed(luma_res_ff)) |->
         ($past(row_hit_w) && $past(line_end_ff)))
      else $error("results written before window height reached");
   a_commit_clears: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      row_hit_w |=> (pcnt_ff[0] == '0 && pcnt_ff[3] == '0 &&
                     acc1_ff[0] == '0 && acc2_ff[3] == '0))
      else $error("window not closed after its last row");
   a_row_count: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (line_end_ff && ly_loc.hit && ly_loc.idx == 2'd0 && !frame_start_i)
         |=> rows_ff[0] == $past(rows_ff[0]) + 16'h0001)
      else $error("window row count did not advance");
   a_sharp_accum: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (cen_hit_w && cx_loc.idx == 2'd0 && !row_hit_w && !frame_start_i)
         |=> (acc1_ff[0] == $past(acc1_ff[0]) + $past(sc1_w) &&
              pcnt_ff[0] == $past(pcnt_ff[0]) + CNT_W'(1)))
      else $error("filter magnitude or pixel not accumulated");
   a_luma_trunc: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (row_hit_w && pcnt_ff[0] != '0 &&
       64'(lsum_ff[0]) < 64'(pcnt_ff[0]) * 64'd256) |->
         (64'(avg_w[0]) * 64'(pcnt_ff[0]) <= 64'(lsum_ff[0]) &&
          (64'(avg_w[0]) + 64'd1) * 64'(pcnt_ff[0]) > 64'(lsum_ff[0])))
      else $error("luminance average not truncated quotient");
   a_score_field: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (row_hit_w && ly_loc.idx == 2'd0 && pcnt_ff[0] != '0 && !frame_start_i)
         |=> (s1_res_ff[7:0] == $past(acc1_ff[0][`AFSWF_WGT_UNITY +: 8]) &&
              s2_res_ff[7:0] == $past(acc2_ff[0][`AFSWF_WGT_UNITY +: 8])))
      else $error("sharpness score field wrong");
endmodule
`default_nettype wire

/* verification/afswf_luma_src.sv */
// Luminance source standing in for the colour interpolation stage.
// Assumes the bench calls send_frame; outputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none

module afswf_luma_src (
   // Clock
   input wire logic clock_i,
   // Luminance stream
   output logic frame_start_o,
   output logic line_end_o,
   output logic pix_valid_o,
   output logic [7:0] pix_y_o
);
   initial begin
      frame_start_o = 1'b0;
      line_end_o = 1'b0;
      pix_valid_o = 1'b0;
      pix_y_o = 8'h5A;
   end

   // Idle cycles invert the data so stale luminance never looks valid
   task automatic step(input logic fs, input logic le, input logic pv,
                       input logic [7:0] y);
      @(negedge clock_i);
      frame_start_o = fs;
      line_end_o = le;
      pix_valid_o = pv;
      pix_y_o = pv ? y : ~pix_y_o;
   endtask

   // Flat frame; gap adds a stall cycle after every pixel
   task automatic send_frame(input int cols, input int rows,
                             input logic [7:0] y, input bit gap);
      step(1'b1, 1'b0, 1'b0, 8'h00);
      for (int r = 0; r < rows; r++) begin
         for (int c = 0; c < cols; c++) begin
            step(1'b0, 1'b0, 1'b1, y);
            if (gap) step(1'b0, 1'b0, 1'b0, 8'h00);
         end
         step(1'b0, 1'b1, 1'b0, 8'h00);
      end
      step(1'b0, 1'b0, 1'b0, 8'h00);
   endtask
endmodule

`default_nettype wire

/* verification/tb.sv */
// Self-checking bench of the sharpness window filter.
// Assumes afswf_luma_src feeds pixels; bench drives the register port.
`timescale 1ns/1ps
`default_nettype none
`include "afswf_regs.svh"

module tb;
   import afswf_pkg::*;
   logic clock_i;
   logic rst_n_i;
   logic frame_start;
   logic line_end;
   logic pix_valid;
   afswf_pix_t pix_y;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic rd_valid;
   afswf_reg_t reg_wdata;
   afswf_reg_t rd_data;
   int bad_count;
   int cmp_count;

   afswf_top dut_u (
      .clock_i(clock_i), .rst_n_i(rst_n_i),
      .frame_start_i(frame_start), .line_end_i(line_end),
      .pix_valid_i(pix_valid), .pix_y_i(pix_y),
      .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
      .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
      .reg_rdata_o(rd_data), .reg_rdata_valid_o(rd_valid));

   afswf_luma_src src_u (
      .clock_i(clock_i), .frame_start_o(frame_start),
      .line_end_o(line_end), .pix_valid_o(pix_valid), .pix_y_o(pix_y));

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] seen,
                      input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clock_i);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock_i);
      reg_wr = 1'b0;
   endtask

   // Data is judged in the one cycle that the valid pulse stands
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(negedge clock_i);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock_i);
      chk("read valid", {15'h0000, rd_valid}, 16'h0001);
      chk($sformatf("reg %h", a), rd_data, exp);
      reg_rd = 1'b0;
   endtask

   // Eight result words; the first nw words carry fresh values
   task automatic rd_res(input logic [7:0] base, input int nw,
                         input logic [15:0] fresh, input logic [15:0] old);
      for (int k = 0; k < 8; k++) begin
         rd(base + 8'(k), (k < nw) ? fresh : old);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_regs();
      rd(`AFSWF_WIN_H_OFS, `AFSWF_WIN_H_RST);
      rd(`AFSWF_F1A_OFS, `AFSWF_F1A_RST);
      rd(`AFSWF_F1B_OFS, `AFSWF_F1B_RST);
      rd(`AFSWF_F2A_OFS, `AFSWF_F2A_RST);
      rd(`AFSWF_F2B_OFS, `AFSWF_F2B_RST);
      rd(8'h00, 16'h0000);
      wr(`AFSWF_LUMA_OFS, 16'hFFFF);
      rd(`AFSWF_LUMA_OFS, 16'h0000);
   endtask

   // 2x2 windows, grid at column 8; flat luma 10, all rows complete
   task automatic t_frame_full();
      wr(`AFSWF_WIN_W_OFS, 16'h0002);
      wr(`AFSWF_WIN_H_OFS, 16'h0002);
      rd(`AFSWF_WIN_H_OFS, 16'h0002);
      wr(`AFSWF_F1A_OFS, 16'h0065);
      wr(`AFSWF_F1B_OFS, 16'h0000);
      wr(`AFSWF_F2A_OFS, 16'h0067);
      wr(`AFSWF_F2B_OFS, 16'h0001);
      src_u.send_frame(20, 8, 8'h0A, 1'b0);
      repeat (4) @(negedge clock_i);
      rd_res(`AFSWF_LUMA_OFS, 8, 16'h0A0A, 16'h0000);
      rd_res(`AFSWF_S1_OFS, 8, 16'h2828, 16'h0000);
      rd_res(`AFSWF_S2_OFS, 8, 16'h0000, 16'h0000);
   endtask

   // Bottom grid row short of height keeps the first frame's values
   task automatic t_frame_short();
      wr(`AFSWF_F1A_OFS, 16'h0020);
      wr(`AFSWF_F1B_OFS, 16'h0001);
      wr(`AFSWF_F2A_OFS, 16'hF829);
      wr(`AFSWF_F2B_OFS, 16'h0000);
      src_u.send_frame(20, 7, 8'h14, 1'b1);
      repeat (4) @(negedge clock_i);
      rd_res(`AFSWF_LUMA_OFS, 6, 16'h1414, 16'h0A0A);
      rd_res(`AFSWF_S1_OFS, 6, 16'h5050, 16'h2828);
      rd_res(`AFSWF_S2_OFS, 6, 16'h4040, 16'h0000);
   endtask

   initial begin
      bad_count = 0;
      cmp_count = 0;
      #40000;
      bad_count++;
      summarize();
   end

   initial begin
      rst_n_i = 1'b0;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
      repeat (6) @(negedge clock_i);
      rst_n_i = 1'b1;
      t_regs();
      t_frame_full();
      t_frame_short();
      summarize();
   end
endmodule

`default_nettype wire
